/* design/fsw_consts.svh */
/*
  Constants of the flash security and write latch block: opcodes,
  field positions, reset values and cycle counts.
  Assumes inclusion by bare name from the package and the top module.
*/
`ifndef FSW_CONSTS_SVH
`define FSW_CONSTS_SVH

// Opcodes (values chosen for this block)
`define FSW_OP_LATCH_SET    8'h06
`define FSW_OP_LATCH_CLEAR  8'h04
`define FSW_OP_READ_IDENT   8'h9f
`define FSW_OP_READ_SEC     8'h2b
`define FSW_OP_CONFIG_WR    8'h01
`define FSW_OP_PAGE_WR      8'h02
`define FSW_OP_QPAGE_WR     8'h38
`define FSW_OP_SECTOR_CLR   8'h20
`define FSW_OP_HBLOCK_CLR   8'h52
`define FSW_OP_BLOCK_CLR    8'hd8
`define FSW_OP_CHIP_CLR     8'h60
`define FSW_OP_SUSPEND      8'hb0
`define FSW_OP_RST_ARM      8'h66
`define FSW_OP_RST_GO       8'h99
`define FSW_OP_SEC_WR       8'h2f
`define FSW_OP_SCHEME_WR    8'h68
`define FSW_OP_GLOBAL_LOCK  8'h7e
`define FSW_OP_GLOBAL_FREE  8'h98

// Security byte bit positions
`define FSW_SEC_SCHEME   7
`define FSW_SEC_EFAIL    6
`define FSW_SEC_PFAIL    5
`define FSW_SEC_RSVD     4
`define FSW_SEC_ESUSP    3
`define FSW_SEC_PSUSP    2
`define FSW_SEC_LOCK     1
`define FSW_SEC_FACTORY  0

// Config byte fields and reset values
`define FSW_CFG_DC_HI    7
`define FSW_CFG_DC_LO    6
`define FSW_CFG_ODS_HI   2
`define FSW_CFG_ODS_LO   0
`define FSW_ODS_RST      3'h7
`define FSW_DC_RST       2'h0

// Last opcode clock count (length minus one), data byte boundaries in bits
`define FSW_OPLEN_SINGLE 3'h7
`define FSW_OPLEN_QUAD   3'h1
`define FSW_BYTE1_BITS   5'h08
`define FSW_BYTE2_BITS   5'h10
`define FSW_NB_SAT       5'h1b

// Dummy clock counts
`define FSW_DUMMY_4      4'h4
`define FSW_DUMMY_6      4'h6
`define FSW_DUMMY_8      4'h8
`define FSW_DUMMY_10     4'ha

`endif

/* design/fsw_pkg.sv */
/*
  Types of the flash security and write latch block.
  Assumes fsw_consts.svh on the include path.
*/
`include "fsw_consts.svh"

package fsw_pkg;

  // System-side state
  typedef struct packed {
    logic       cs_m;      // Chip select sync, first stage
    logic       cs_s;      // Chip select sync, second stage
    logic       cs_p;      // Previous synced chip select
    logic       write_latch_flag;       // Write enable latch
    logic       scheme;    // Protection scheme select
    logic       efail;     // Erase fault
    logic       pfail;     // Program fault
    logic       esusp;     // Erase paused
    logic       psusp;     // Program paused
    logic       lock;      // OTP lockdown
    logic       factory;   // OTP factory lock indicator
    logic       cap;       // Factory strap captured
    logic       rst_arm;   // Soft reset armed
    logic [1:0] dc;        // Dummy count select
    logic [2:0] ods;       // Drive select
    logic [7:0] drv;       // One-hot drive level
    logic [3:0] d_std;     // Dummy clocks, plain reads
    logic [3:0] d_dio;     // Dummy clocks, dual io reads
    logic [3:0] d_qio;     // Dummy clocks, quad io reads
    logic       acv;       // Array command pulse
    logic [7:0] acmd;      // Array command opcode
  } fsw_sys_t;

  // Link-side state kept across frames
  typedef struct packed {
    logic [9:0] m1;        // Sync first stage: mode, busy, security
    logic [9:0] m2;        // Sync second stage
    logic [7:0] op;        // Last opcode seen
    logic [4:0] nb;        // Data bits after opcode
    logic [7:0] dat;       // Last data byte
  } fsw_hold_t;

  // Link-side state of one frame
  typedef struct packed {
    logic [2:0]  cnt;      // Opcode clock count
    logic        opdone;   // Opcode complete
    logic        talk;     // Driving answer lines
    logic [7:0]  op;       // Opcode shifter
    logic [4:0]  nb;       // Data bit count, saturating
    logic [7:0]  dat;      // Data shifter
    logic [23:0] sh;       // Answer shifter
    logic [3:0]  io;       // Output lines
    logic [3:0]  oe;       // Output enables
  } fsw_frame_t;

endpackage

/* design/fsw_top.sv */
/*
  Command-side register logic of a serial flash: write latch,
  security byte, drive and dummy configuration, identity read.
  Assumes a host on chip select, link clock and four data lines, and
  an array engine on clk_sys_i that reports its own events.
*/
// What this block does
// - Drive field decodes eight levels, 111 default
// - Plain fast reads: dummy 8,6,8,10 clocks
// - Dual io 4,6,8,10; quad io 6,4,8,10
// - Erase fault bit6 set on fail, clears
// - Program fault bit5 set on fail, clears
// - Erase paused bit3 follows suspend and resume
// - Program paused bit2 follows suspend and resume
// - Bit0 shows factory OTP lock
// - Lockdown bit1 set only by security write
// - OTP mode refuses main array access
// - Bit7 selects scheme, default 0, one-time
// - Latch set command sets write latch
// - Opcode 8 clocks single, 2 quad
// - Latch clear command resets write latch
// - Reset and listed commands clear write latch
// - Identity read shifts out 24 bits, single line mode only
// - Busy array: identity read not decoded
// - Program and erase need write latch
// - Drive bits written by config write
`timescale 1ns/100ps
`default_nettype none
`include "fsw_consts.svh"

module fsw_top
  import fsw_pkg::*;
#(
  parameter logic [23:0] IDENT = 24'ha5_5a_01  // Arbitrary identity value
) (
  // System clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  // Link to host
  input  wire logic       sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic [3:0] io_i,
  output logic      [3:0] io_o,
  output logic      [3:0] io_oe_o,
  // Array engine status
  input  wire logic       four_line_mode_i,
  input  wire logic       otp_mode_i,
  input  wire logic       otp_factory_i,
  input  wire logic       busy_i,
  input  wire logic       pgm_done_i,
  input  wire logic       pgm_ok_i,
  input  wire logic       ers_done_i,
  input  wire logic       ers_ok_i,
  input  wire logic       pgm_susp_i,
  input  wire logic       pgm_resume_i,
  input  wire logic       ers_susp_i,
  input  wire logic       ers_resume_i,
  // Outputs to array and pads
  output logic            array_cmd_valid_o,
  output logic      [7:0] array_cmd_o,
  output logic            write_latch_flag_o,
  output logic      [7:0] sec_byte_o,
  output logic      [2:0] drive_sel_o,
  output logic      [7:0] drive_level_o,
  output logic      [3:0] dummy_std_o,
  output logic      [3:0] dummy_dio_o,
  output logic      [3:0] dummy_qio_o
);

  ////////////////////////////////////////////////////////////////////
  // Dummy clock lookup; cls 0 plain, 1 dual io, 2 quad io
  function automatic logic [3:0] dummy_of(input logic [1:0] dc,
                                           input logic [1:0] cls);
    logic [3:0] r;
    r = `FSW_DUMMY_10;
    unique case (dc)
      2'h3: r = (cls == 2'h1) ? `FSW_DUMMY_4 :
                (cls == 2'h2) ? `FSW_DUMMY_6 : `FSW_DUMMY_8;
      2'h2: r = (cls == 2'h2) ? `FSW_DUMMY_4 : `FSW_DUMMY_6;
      2'h1: r = `FSW_DUMMY_8;
      2'h0: r = `FSW_DUMMY_10;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Link domain; frame state dies with chip select
  fsw_frame_t f_q;        // Frame state
  fsw_frame_t f_d;        // Frame next state
  fsw_hold_t  l_q;        // Held link state
  fsw_hold_t  l_d;        // Held next state
  logic       quad;       // Synced four-line mode
  logic       lbusy;      // Synced array busy

  assign quad  = l_q.m2[9];
  assign lbusy = l_q.m2[8];

  // Opcode and data shifting, answer loading
  always_comb begin
    f_d = f_q;
    l_d = l_q;
    l_d.m1 = {four_line_mode_i, busy_i, sec_byte_o};
    l_d.m2 = l_q.m1;
    if (!f_q.opdone) begin
      // Single line reads io 0 only
      f_d.op = quad ? {f_q.op[3:0], io_i} : {f_q.op[6:0], io_i[0]};
      f_d.cnt = f_q.cnt + 3'h1;
      if (f_q.cnt == (quad ? `FSW_OPLEN_QUAD : `FSW_OPLEN_SINGLE)) begin
        f_d.opdone = 1'b1;
        // Identity only in single line mode and idle array
        if (f_d.op == `FSW_OP_READ_IDENT && !quad && !lbusy) begin
          f_d.sh   = IDENT;
          f_d.talk = 1'b1;
        end else if (f_d.op == `FSW_OP_READ_SEC) begin
          f_d.sh   = {l_q.m2[7:0], 16'h0000};
          f_d.talk = 1'b1;
        end
      end
    end else begin
      // Data phase; shift in and shift answer out
      f_d.dat = quad ? {f_q.dat[3:0], io_i} : {f_q.dat[6:0], io_i[0]};
      f_d.nb  = (f_q.nb > `FSW_NB_SAT) ? 5'h1f :
                f_q.nb + (quad ? 5'h04 : 5'h01);
      f_d.sh  = quad ? {f_q.sh[19:0], 4'h0} : {f_q.sh[22:0], 1'b0};
    end
    // Answer lines; single line talks on io 1
    f_d.io = quad ? f_d.sh[23:20] : {2'b00, f_d.sh[23], 1'b0};
    f_d.oe = !f_d.talk ? 4'h0 : (quad ? 4'hf : 4'h2);
    l_d.op  = f_d.op;
    l_d.nb  = f_d.nb;
    l_d.dat = f_d.dat;
  end

  // Frame register, cleared whenever the host deselects
  always_ff @(posedge sclk_i or posedge cs_n_i or negedge nrst_i) begin
    if (!nrst_i || cs_n_i) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  // Held register; stable after the last edge of a frame
  always_ff @(posedge sclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  assign io_o    = f_q.io;
  assign io_oe_o = f_q.oe;

  ////////////////////////////////////////////////////////////////////
  // System domain; decodes a frame once chip select has risen
  fsw_sys_t s_q;          // System state
  fsw_sys_t s_d;          // System next state
  logic     fend;         // Frame end pulse
  logic     is_array;     // Opcode is program or erase
  logic     bound;        // Ended after one or two whole data bytes

  assign fend = s_q.cs_s && !s_q.cs_p;
  assign is_array = l_q.op inside {`FSW_OP_PAGE_WR, `FSW_OP_QPAGE_WR,
                    `FSW_OP_SECTOR_CLR, `FSW_OP_HBLOCK_CLR,
                    `FSW_OP_BLOCK_CLR, `FSW_OP_CHIP_CLR};
  assign bound = l_q.nb == `FSW_BYTE1_BITS ||
                 l_q.nb == `FSW_BYTE2_BITS;

  // Command effects, then array events which win over them
  always_comb begin
    s_d = s_q;
    s_d.cs_m = cs_n_i;
    s_d.cs_s = s_q.cs_m;
    s_d.cs_p = s_q.cs_s;
    s_d.acv  = 1'b0;
    if (!s_q.cap) begin
      s_d.factory = otp_factory_i;
      s_d.cap     = 1'b1;
    end
    if (fend) begin
      s_d.rst_arm = l_q.op == `FSW_OP_RST_ARM;
      unique case (l_q.op)
        `FSW_OP_LATCH_SET:   s_d.write_latch_flag = 1'b1;
        `FSW_OP_LATCH_CLEAR: s_d.write_latch_flag = 1'b0;
        `FSW_OP_CONFIG_WR: begin
          // Rejected unless latched and ended after one or two whole data bytes
          if (s_q.write_latch_flag && bound) begin
            s_d.write_latch_flag = 1'b0;
            if (l_q.nb == `FSW_BYTE2_BITS) begin
              s_d.ods = l_q.dat[`FSW_CFG_ODS_HI:`FSW_CFG_ODS_LO];
              s_d.dc  = l_q.dat[`FSW_CFG_DC_HI:`FSW_CFG_DC_LO];
            end
          end
        end
        `FSW_OP_SEC_WR: begin
          // Lockdown can only go to one
          if (s_q.write_latch_flag) begin
            s_d.lock = 1'b1;
            s_d.write_latch_flag  = 1'b0;
          end
        end
        `FSW_OP_SCHEME_WR: begin
          if (s_q.write_latch_flag) begin
            s_d.scheme = 1'b1;
            s_d.write_latch_flag    = 1'b0;
          end
        end
        `FSW_OP_SUSPEND, `FSW_OP_GLOBAL_LOCK,
        `FSW_OP_GLOBAL_FREE: s_d.write_latch_flag = 1'b0;
        `FSW_OP_RST_GO: begin
          if (s_q.rst_arm) begin
            s_d.write_latch_flag = 1'b0;
          end
        end
        default: begin
          // Array commands pass only latched, idle and outside OTP
          if (is_array && s_q.write_latch_flag) begin
            s_d.write_latch_flag = 1'b0;
            s_d.acv = !busy_i && !otp_mode_i;
            s_d.acmd = l_q.op;
          end
        end
      endcase
    end
    // Fault flags never stop the array, they only report
    if (ers_done_i) begin
      s_d.efail = !ers_ok_i;
    end
    if (pgm_done_i) begin
      s_d.pfail = !pgm_ok_i;
    end
    if (ers_resume_i) begin
      s_d.esusp = 1'b0;
    end
    if (ers_susp_i) begin
      s_d.esusp = 1'b1;
    end
    if (pgm_resume_i) begin
      s_d.psusp = 1'b0;
    end
    if (pgm_susp_i) begin
      s_d.psusp = 1'b1;
    end
    s_d.drv   = 8'h01 << s_d.ods;
    s_d.d_std = dummy_of(s_d.dc, 2'h0);
    s_d.d_dio = dummy_of(s_d.dc, 2'h1);
    s_d.d_qio = dummy_of(s_d.dc, 2'h2);
  end

  // Latch cleared by reset pin as well
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '{cs_m: 1'b1, cs_s: 1'b1, cs_p: 1'b1, ods: `FSW_ODS_RST,
               dc: `FSW_DC_RST, drv: 8'h80, d_std: `FSW_DUMMY_10,
               d_dio: `FSW_DUMMY_10, d_qio: `FSW_DUMMY_10,
               default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign array_cmd_valid_o  = s_q.acv;
  assign array_cmd_o        = s_q.acmd;
  assign write_latch_flag_o = s_q.write_latch_flag;
  assign sec_byte_o = {s_q.scheme, s_q.efail, s_q.pfail, 1'b0,
                       s_q.esusp, s_q.psusp, s_q.lock, s_q.factory};
  assign drive_sel_o   = s_q.ods;
  assign drive_level_o = s_q.drv;
  assign dummy_std_o   = s_q.d_std;
  assign dummy_dio_o   = s_q.d_dio;
  assign dummy_qio_o   = s_q.d_qio;

  ////////////////////////////////////////////////////////////////////
  // Checks
  a_latch_set: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) fend && l_q.op == `FSW_OP_LATCH_SET |=>
    write_latch_flag_o) else $error("latch set did not set latch");
  a_latch_clear: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) fend && l_q.op == `FSW_OP_LATCH_CLEAR |=>
    !write_latch_flag_o) else $error("latch clear did not clear latch");
  a_array_gate: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) array_cmd_valid_o |-> $past(s_q.write_latch_flag) &&
    !write_latch_flag_o) else $error("array command without latch");
  a_otp_refuse: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) otp_mode_i |=> !array_cmd_valid_o)
    else $error("array command in OTP mode");
  a_lock_sticky: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) sec_byte_o[1] |=> sec_byte_o[1] [*3])
    else $error("lockdown bit dropped");
  a_efail_set: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) ers_done_i && !ers_ok_i |=> sec_byte_o[6])
    else $error("erase fault not set");
  a_pfail_clear: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) pgm_done_i && pgm_ok_i |=> !sec_byte_o[5])
    else $error("program fault not cleared");
  a_esusp_set: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) ers_susp_i |=> sec_byte_o[3])
    else $error("erase paused not set");
  a_psusp_clear: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) pgm_resume_i && !pgm_susp_i |=> !sec_byte_o[2])
    else $error("program paused not cleared");
  a_dummy_map: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) s_q.dc == 2'h3 |-> dummy_std_o == 4'h8 &&
    dummy_dio_o == 4'h4 && dummy_qio_o == 4'h6)
    else $error("dummy map wrong for code 11");
  a_rsvd_zero: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) !sec_byte_o[4])
    else $error("reserved bit set");
  a_drive_onehot: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) $onehot(drive_level_o) && drive_level_o[drive_sel_o])
    else $error("drive level decode wrong");
  a_ident_quiet: assert property (@(posedge sclk_i)
    disable iff (cs_n_i) lbusy && !f_q.opdone |=>
    !(f_q.talk && f_q.op == `FSW_OP_READ_IDENT))
    else $error("identity read decoded while busy");

endmodule

`default_nettype wire

/* verification/fsw_host_model.sv */
/*
  Host controller model on the serial link of the flash block.
  Assumes the bench calls xfer and keeps the mode flag in step.
*/
`timescale 1ns/100ps
`default_nettype none

module fsw_host_model (
  // Link to the device
  output logic            sclk_o,
  output logic            cs_n_o,
  output logic      [3:0] io_o,
  // Answer lines from the device
  input  wire logic [3:0] dev_io_i,
  input  wire logic [3:0] dev_oe_i
);
  logic [3:0] oe_seen;  // Enables seen while sampling

  // Idle: clock parked low, select high
  initial begin
    sclk_o  = 1'b0;
    cs_n_o  = 1'b1;
    io_o    = 4'h5;
    oe_seen = 4'h0;
  end

  // One frame; the clock runs only inside it, 48 ns period
  task automatic xfer(input logic [7:0] op, input logic quad,
                      input int nwr, input logic [15:0] wd,
                      input int nrd, output logic [23:0] rd);
    int nop;
    nop = quad ? 2 : 8;
    rd = 24'h0;
    oe_seen = 4'h0;
    cs_n_o = 1'b0;
    #24;
    for (int i = 0; i < nop + nwr + nrd; i++) begin
      // Upper lines churn in single mode so they must be ignored
      if (i < nop && quad)
        io_o = op[7 - 4 * i -: 4];
      else if (i < nop)
        io_o = {~io_o[3:1], op[7 - i]};
      else if (i < nop + nwr)
        io_o = {~io_o[3:1], wd[nwr - 1 - (i - nop)]};
      else
        io_o = ~io_o;
      #24 sclk_o = 1'b1;
      #24 sclk_o = 1'b0;
      // Answer bit stands a full period; look mid-way
      if (i >= nop - 1 && i < nop - 1 + nrd) begin
        rd = {rd[22:0], dev_io_i[1]};
        oe_seen = oe_seen | dev_oe_i;
      end
    end
    // Frame ends right after the last unit, no trailing bytes
    #24 cs_n_o = 1'b1;
    io_o = ~io_o;
    #60;
  endtask
endmodule
`default_nettype wire

/* verification/tb.sv */
/*
  Self-checking bench of the flash security and write latch block.
  Assumes fsw_top and the host model; link clock from the host only.
*/
`timescale 1ns/100ps
`default_nettype none

module tb
  import fsw_pkg::*;
;
  localparam logic [23:0] IDENT = 24'h3c_c3_5a; // Arbitrary value
  logic       clk_sys_i, nrst_i, mode, otp, fact, busy, p_ok, e_ok;
  logic [5:0] ev;       // Event pulses: done, done, susp, res, susp, res
  logic       sclk, cs_n, valid, latch;
  logic [3:0] hio, io, oe, d_std, d_dio, d_qio;
  logic [7:0] cmd_o, sec, lvl, last_cmd;
  logic [2:0] dsel;
  logic [23:0] rd;
  int         fails = 0, comparisons = 0, pulses = 0;
  // Expected dummy clocks by select code 0..3
  logic [3:0] std_t [4] = '{4'ha, 4'h8, 4'h6, 4'h8};
  logic [3:0] dio_t [4] = '{4'ha, 4'h8, 4'h6, 4'h4};
  logic [3:0] qio_t [4] = '{4'ha, 4'h8, 4'h4, 4'h6};
  logic [7:0] arr_t [6] = '{8'h02, 8'h38, 8'h20, 8'h52, 8'hd8, 8'h60};
  logic [7:0] clr_t [4] = '{8'h04, 8'hb0, 8'h7e, 8'h98};

  fsw_top #(.IDENT(IDENT)) dut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .io_i(hio), .io_o(io), .io_oe_o(oe),
    .four_line_mode_i(mode), .otp_mode_i(otp), .otp_factory_i(fact),
    .busy_i(busy), .pgm_done_i(ev[0]), .pgm_ok_i(p_ok),
    .ers_done_i(ev[1]), .ers_ok_i(e_ok), .pgm_susp_i(ev[2]),
    .pgm_resume_i(ev[3]), .ers_susp_i(ev[4]), .ers_resume_i(ev[5]),
    .array_cmd_valid_o(valid), .array_cmd_o(cmd_o),
    .write_latch_flag_o(latch), .sec_byte_o(sec), .drive_sel_o(dsel),
    .drive_level_o(lvl), .dummy_std_o(d_std), .dummy_dio_o(d_dio),
    .dummy_qio_o(d_qio));

  fsw_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .io_o(hio),
    .dev_io_i(io), .dev_oe_i(oe));

  ////////////////////////////////////////////////////////////////////////
  // System clock, 5 ns
  initial clk_sys_i = 1'b0;
  always #2.5 clk_sys_i = ~clk_sys_i;

  // Count array pulses; one-cycle pulse sampled at each rising edge
  always @(posedge clk_sys_i) begin
    if (valid === 1'b1) begin
      pulses <= pulses + 1;
      last_cmd <= cmd_o;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // Opcode-only frame in single-line mode
  task automatic cmd(input logic [7:0] op);
    host.xfer(op, 1'b0, 0, 16'h0, 0, rd);
  endtask

  // Array event pulse with its success qualifier
  task automatic evt(input int k, input logic ok);
    @(posedge clk_sys_i);
    ev[k] <= 1'b1;
    p_ok <= ok;
    e_ok <= ok;
    @(posedge clk_sys_i);
    ev <= 6'h0;
    tick(2);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check(latch, 1'b0);
    check({dsel, lvl}, {3'h7, 8'h80});
    check({d_std, d_dio, d_qio}, 12'haaa);
    check(sec, 8'h01);
  endtask

  task automatic t_latch();
    cmd(8'h06);
    check(latch, 1'b1);
    cmd(8'h04);
    check(latch, 1'b0);
    // Four-line mode needs a frame for the mode to settle
    @(posedge clk_sys_i) mode <= 1'b1;
    host.xfer(8'h00, 1'b1, 0, 16'h0, 0, rd);
    host.xfer(8'h06, 1'b1, 0, 16'h0, 0, rd);
    check(latch, 1'b1);
    host.xfer(8'h9f, 1'b1, 0, 16'h0, 24, rd);
    check(host.oe_seen, 4'h0);
    host.xfer(8'h04, 1'b1, 0, 16'h0, 0, rd);
    check(latch, 1'b0);
    @(posedge clk_sys_i) mode <= 1'b0;
    cmd(8'h00);
  endtask

  task automatic t_cfg();
    logic [1:0] d;
    logic [2:0] s;
    for (int i = 0; i < 8; i++) begin
      d = i[1:0];
      s = i[2:0] ^ 3'h5;
      cmd(8'h06);
      host.xfer(8'h01, 1'b0, 16, {8'h00, d, 3'h0, s}, 0, rd);
      check(dsel, s);
      check(lvl, 8'h01 << s);
      check(d_std, std_t[d]);
      check({d_dio, d_qio}, {dio_t[d], qio_t[d]});
      check(latch, 1'b0);
    end
    // Write ending off a byte boundary is refused
    cmd(8'h06);
    host.xfer(8'h01, 1'b0, 12, 16'h0005, 0, rd);
    check(dsel, 3'h2);
    check(latch, 1'b1);
    // Refused write leaves the latch up; drop it before array tests
    cmd(8'h04);
    check(latch, 1'b0);
  endtask

  task automatic t_array();
    int p;
    p = pulses;
    cmd(8'h02);
    check(pulses, p);
    foreach (arr_t[k]) begin
      cmd(8'h06);
      cmd(arr_t[k]);
      check(pulses, p + k + 1);
      check(last_cmd, arr_t[k]);
      check(latch, 1'b0);
    end
    p = pulses;
    @(posedge clk_sys_i) otp <= 1'b1;
    cmd(8'h06);
    cmd(8'h02);
    check(pulses, p);
    @(posedge clk_sys_i) otp <= 1'b0;
    busy <= 1'b1;
    cmd(8'h06);
    cmd(8'h20);
    check(pulses, p);
    host.xfer(8'h9f, 1'b0, 0, 16'h0, 24, rd);
    check(host.oe_seen, 4'h0);
    @(posedge clk_sys_i) busy <= 1'b0;
    cmd(8'h00);
    host.xfer(8'h9f, 1'b0, 0, 16'h0, 24, rd);
    check(rd, IDENT);
    check(host.oe_seen, 4'h2);
    // Cut short after the first byte
    host.xfer(8'h9f, 1'b0, 0, 16'h0, 8, rd);
    check(rd[7:0], IDENT[23:16]);
    check(oe, 4'h0);
  endtask

  task automatic t_flags();
    for (int b = 5; b < 7; b++) begin
      evt(b - 5, 1'b0);
      check(sec[b], 1'b1);
      evt(b - 5, 1'b1);
      check(sec[b], 1'b0);
    end
    for (int k = 0; k < 2; k++) begin
      evt(2 + 2 * k, 1'b1);
      check(sec[2 + k], 1'b1);
      evt(3 + 2 * k, 1'b1);
      check(sec[2 + k], 1'b0);
    end
  endtask

  task automatic t_sec();
    cmd(8'h2f);
    check(sec[1], 1'b0);
    cmd(8'h06);
    cmd(8'h2f);
    check({sec[1], latch}, 2'h2);
    cmd(8'h06);
    cmd(8'h68);
    check({sec[7], sec[4], latch}, 3'h4);
    foreach (clr_t[k]) begin
      cmd(8'h06);
      cmd(clr_t[k]);
      check(latch, 1'b0);
    end
    // Security byte read back over the link: scheme, lock, factory
    host.xfer(8'h2b, 1'b0, 0, 16'h0, 8, rd);
    check(rd[7:0], 8'h83);
    cmd(8'h06);
    cmd(8'h99);
    check(latch, 1'b1);
    cmd(8'h66);
    cmd(8'h99);
    check(latch, 1'b0);
    cmd(8'h06);
    @(posedge clk_sys_i) nrst_i <= 1'b0;
    tick(3);
    check(latch, 1'b0);
    nrst_i <= 1'b1;
    tick(4);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Main sequence; reset held 16 cycles
  initial begin
    {nrst_i, mode, otp, busy, p_ok, e_ok, ev} = 12'h0;
    fact = 1'b1;
    tick(16);
    nrst_i <= 1'b1;
    tick(4);
    t_reset();
    t_latch();
    t_cfg();
    t_array();
    t_flags();
    t_sec();
    report_and_stop();
  end

  // Watchdog well beyond the expected run time
  initial begin
    #400000;
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire
